// *** hdl/completion_entry_builder_map.svh ***
/*
  Offsets, field positions, reset values and size limits for the completion record builder.
  Assumes inclusion by bare name from design files; holds definitions only.
*/
`ifndef COMPLETION_ENTRY_BUILDER_MAP_SVH
`define COMPLETION_ENTRY_BUILDER_MAP_SVH

`define REG_CTRL_OFS 8'h00
`define REG_RING_BASE_LO_OFS 8'h04
`define REG_RING_BASE_HI_OFS 8'h08
`define REG_RING_SIZE_OFS 8'h0C
`define REG_RING_STATE_OFS 8'h10
`define REG_IRQ_STATUS_OFS 8'h14
`define REG_IRQ_ENABLE_OFS 8'h18
`define REG_IRQ_CLEAR_OFS 8'h1C
`define REG_POSTED_CNT_OFS 8'h20

`define CTRL_RUN_BIT 0
`define IRQ_POSTED_BIT 0
`define IRQ_WRAP_BIT 1
`define IRQ_OVERRUN_BIT 2
`define IRQ_WIDTH 3

`define DW2_SQ_TAG_HI 31
`define DW2_SQ_TAG_LO 16
`define DW2_HEAD_HI 15
`define DW2_HEAD_LO 0
`define DW3_STATUS_HI 31
`define DW3_STATUS_LO 17
`define DW3_PHASE_BIT 16
`define DW3_CMD_TAG_HI 15
`define DW3_CMD_TAG_LO 0
`define STATUS_CATEGORY_HI 10
`define STATUS_CATEGORY_LO 8
`define STATUS_DETAIL_HI 7
`define STATUS_DETAIL_LO 0

`define RECORD_BYTES 16
`define RECORD_DWORDS 4
`define RING_SIZE_RESET 16'h0010
`define PHASE_RESET 1'b1
`define MAX_OUTSTANDING 65536

`endif

// *** hdl/completion_entry_builder_pkg.sv ***
/*
  Types shared by the completion record builder files.
  Assumes the map header supplies numeric constants.
*/
package completion_entry_builder_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_WAIT = 2'b10
  } post_state_t;

  typedef logic [31:0] dword_t;
endpackage : completion_entry_builder_pkg

// *** hdl/status_code_picker.sv ***
/*
  Picks the lowest numbered detail code among the flagged candidates and forms the status word.
  Assumes candidate flags come from logic on the same clock.
*/
`timescale 1ns/100ps
`include "completion_entry_builder_map.svh"

module status_code_picker #(
  parameter int CODES = 8
) (
  input wire logic [CODES-1:0] code_flags_in,
  input wire logic [CODES*8-1:0] code_values_in,
  input wire logic [2:0] status_category_in,
  input wire logic dnr_in,
  input wire logic more_in,
  output logic [14:0] status_word_out,
  output logic any_error_out
);
  initial begin
    if (CODES < 1 || CODES > 256) $error("CODES out of range");
  end

  logic [7:0] best [CODES:0];
  logic [CODES:0] found;
  assign best[0] = 8'hFF;
  assign found[0] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < CODES; g++) begin : g_pick
      wire logic [7:0] cand = code_values_in[g*8 +: 8];
      wire logic take = code_flags_in[g] && (!found[g] || cand < best[g]);
      assign best[g+1] = take ? cand : best[g];
      assign found[g+1] = found[g] | code_flags_in[g];
    end
  endgenerate

  assign any_error_out = found[CODES];
  // A clean completion reports an all-zero word.
  assign status_word_out = found[CODES] ?
    {dnr_in, more_in, 2'b00, status_category_in, best[CODES]} : 15'h0000;
endmodule : status_code_picker

// *** hdl/ring_tail_tracker.sv ***
/*
  Tail index and pass flag of one completion ring.
  Assumes advance pulses only while the run bit is high.
*/
`timescale 1ns/100ps
`include "completion_entry_builder_map.svh"

module ring_tail_tracker #(
  parameter int IDX_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic run_in,
  input wire logic advance_in,
  input wire logic [IDX_W-1:0] ring_last_in,
  output logic [IDX_W-1:0] tail_out,
  output logic phase_out,
  output logic wrap_out
);
  initial begin
    if (IDX_W < 1 || IDX_W > 16) $error("IDX_W out of range");
  end

  logic [IDX_W-1:0] tail_q;
  logic phase_q;
  wire logic at_last = tail_q >= ring_last_in;
  assign wrap_out = advance_in && at_last;

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tail_q <= '0;
      phase_q <= `PHASE_RESET;
    end else if (clk_en_in) begin
      if (!run_in) begin
        tail_q <= '0;
        phase_q <= `PHASE_RESET;
      end else if (advance_in) begin
        tail_q <= at_last ? '0 : tail_q + 1'b1;
        phase_q <= at_last ? ~phase_q : phase_q;
      end
    end
  end

  assign tail_out = tail_q;
  assign phase_out = phase_q;
endmodule : ring_tail_tracker

// *** hdl/completion_entry_builder.sv ***
/*
  Completion record builder: takes finished commands, forms 16-byte records and writes them
  as four dwords to the host completion ring, with AXI4-Lite registers and an interrupt.
  Assumes a memory write port that accepts one dword per valid/ready handshake and that
  completion requests come from logic on sys_clk_in.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
// Contract
// - Every record is sixteen bytes, four 32-bit dwords numbered zero to three.
// - Dword zero carries the command result or zero; dword one is reserved zero.
// - Dword two bits 31..16 hold the submission queue tag.
// - Dword two bits 15..0 hold head snapshot captured at record creation.
// - Dword three bits 31..17 hold the completion status word.
// - Dword three bit 16 holds the inverted new-entry flag of the slot.
// - First pass posts flag one, then alternates each wrap.
// - Dword three bits 15..0 copy the host assigned command tag.
// - Up to 64K outstanding requests; command tag tracking is 16 bits.
// - A clean completion reports an all-zero status word.
// - Status category sits in dword three bits 27..25.
// - Detailed status code sits in dword three bits 24..17.
// - Among several applicable codes the lowest numeric value is reported.
`timescale 1ns/100ps
`include "completion_entry_builder_map.svh"

module completion_entry_builder #(
  parameter int CODES = 8,
  parameter int IDX_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic cpl_valid_in,
  output logic cpl_ready_out,
  input wire logic [15:0] submission_queue_tag_in,
  input wire logic [15:0] queue_head_snapshot_in,
  input wire logic [15:0] command_tag_in,
  input wire logic [31:0] result_in,
  input wire logic result_used_in,
  input wire logic [2:0] status_category_in,
  input wire logic [CODES-1:0] code_flags_in,
  input wire logic [CODES*8-1:0] code_values_in,
  input wire logic dnr_in,
  input wire logic more_in,
  output logic mem_valid_out,
  input wire logic mem_ready_in,
  output logic [63:0] mem_addr_out,
  output logic [31:0] mem_data_out,
  output logic irq_out
);
  initial begin
    if (`MAX_OUTSTANDING > (1 << 16)) $error("Command tag width too small");
    if (CODES < 1) $error("CODES must be positive");
  end

  // Register state.
  logic run_q;
  logic [31:0] base_lo_q;
  logic [31:0] base_hi_q;
  logic [15:0] ring_size_q;
  logic [`IRQ_WIDTH-1:0] irq_status_q;
  logic [`IRQ_WIDTH-1:0] irq_enable_q;
  logic [31:0] posted_cnt_q;

  // AXI slave state.
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Record posting state.
  completion_entry_builder_pkg::post_state_t state_q;
  completion_entry_builder_pkg::dword_t rec_q [`RECORD_DWORDS];
  logic [1:0] dw_idx_q;
  logic [IDX_W-1:0] slot_q;
  logic mem_valid_q;
  logic [63:0] mem_addr_q;
  logic [31:0] mem_data_q;

  // Status word and ring tracking.
  wire logic [14:0] status_word;
  wire logic any_error;
  wire logic [IDX_W-1:0] tail;
  wire logic phase;
  wire logic wrap;

  status_code_picker #(.CODES(CODES)) u_pick (
    .code_flags_in(code_flags_in),
    .code_values_in(code_values_in),
    .status_category_in(status_category_in),
    .dnr_in(dnr_in),
    .more_in(more_in),
    .status_word_out(status_word),
    .any_error_out(any_error)
  );

  wire logic last_dw_done = (state_q == completion_entry_builder_pkg::ST_WRITE) &&
    mem_valid_q && mem_ready_in && (dw_idx_q == 2'd3);
  wire logic [IDX_W-1:0] ring_last = IDX_W'(ring_size_q - 16'h0001);

  ring_tail_tracker #(.IDX_W(IDX_W)) u_tail (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .run_in(run_q),
    .advance_in(last_dw_done),
    .ring_last_in(ring_last),
    .tail_out(tail),
    .phase_out(phase),
    .wrap_out(wrap)
  );

  // Completion intake and record assembly.
  wire logic accept = cpl_valid_in && cpl_ready_out;
  assign cpl_ready_out = run_q && (state_q == completion_entry_builder_pkg::ST_IDLE);
  wire logic overrun = cpl_valid_in && !run_q;

  wire logic [31:0] dw0 = result_used_in ? result_in : 32'h0000_0000;
  wire logic [31:0] dw1 = 32'h0000_0000;
  wire logic [31:0] dw2 = {submission_queue_tag_in, queue_head_snapshot_in};
  wire logic [31:0] dw3 = {status_word, phase, command_tag_in};

  wire logic [63:0] base = {base_hi_q, base_lo_q};
  wire logic [63:0] slot_addr = base + 64'(slot_q) * 64'(`RECORD_BYTES);

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= completion_entry_builder_pkg::ST_IDLE;
      dw_idx_q <= 2'd0;
      slot_q <= '0;
      for (int i = 0; i < `RECORD_DWORDS; i++) rec_q[i] <= 32'h0000_0000;
    end else if (clk_en_in) begin
      case (state_q)
        completion_entry_builder_pkg::ST_IDLE: begin
          if (accept) begin
            rec_q[0] <= dw0;
            rec_q[1] <= dw1;
            rec_q[2] <= dw2;
            rec_q[3] <= dw3;
            slot_q <= tail;
            dw_idx_q <= 2'd0;
            state_q <= completion_entry_builder_pkg::ST_WAIT;
          end
        end
        completion_entry_builder_pkg::ST_WAIT: begin
          state_q <= completion_entry_builder_pkg::ST_WRITE;
        end
        completion_entry_builder_pkg::ST_WRITE: begin
          if (mem_valid_q && mem_ready_in) begin
            dw_idx_q <= dw_idx_q + 2'd1;
            if (dw_idx_q == 2'd3) begin
              state_q <= completion_entry_builder_pkg::ST_IDLE;
            end
          end
        end
        default: state_q <= completion_entry_builder_pkg::ST_IDLE;
      endcase
    end
  end

  // Memory write channel; the flag dword goes last so a record is whole when seen new.
  wire logic load_dw = (state_q == completion_entry_builder_pkg::ST_WAIT) ||
    ((state_q == completion_entry_builder_pkg::ST_WRITE) && mem_valid_q && mem_ready_in &&
    (dw_idx_q != 2'd3));
  wire logic [1:0] next_idx = (state_q == completion_entry_builder_pkg::ST_WAIT) ? 2'd0 :
    dw_idx_q + 2'd1;
  wire logic [63:0] dw_addr = slot_addr + 64'({next_idx, 2'b00});

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mem_valid_q <= 1'b0;
      mem_addr_q <= 64'h0000_0000_0000_0000;
      mem_data_q <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if (load_dw) begin
        mem_valid_q <= 1'b1;
        mem_addr_q <= dw_addr;
        mem_data_q <= rec_q[next_idx];
      end else if (mem_valid_q && mem_ready_in) begin
        mem_valid_q <= 1'b0;
      end
    end
  end

  assign mem_valid_out = mem_valid_q;
  assign mem_addr_out = mem_addr_q;
  assign mem_data_out = mem_data_q;

  // AXI4-Lite write path.
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  wire logic do_write = aw_have_q && w_have_q && !bvalid_q;
  wire logic [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}},
    {8{w_strb_q[0]}}};
  wire logic wr_ctrl = do_write && (aw_addr_q == `REG_CTRL_OFS);
  wire logic wr_lo = do_write && (aw_addr_q == `REG_RING_BASE_LO_OFS);
  wire logic wr_hi = do_write && (aw_addr_q == `REG_RING_BASE_HI_OFS);
  wire logic wr_size = do_write && (aw_addr_q == `REG_RING_SIZE_OFS);
  wire logic wr_en = do_write && (aw_addr_q == `REG_IRQ_ENABLE_OFS);
  wire logic wr_clr = do_write && (aw_addr_q == `REG_IRQ_CLEAR_OFS);
  wire logic wr_ok = wr_ctrl || wr_lo || wr_hi || wr_size || wr_en || wr_clr;
  wire logic [31:0] merged_lo = (base_lo_q & ~wmask) | (w_data_q & wmask);
  wire logic [31:0] merged_hi = (base_hi_q & ~wmask) | (w_data_q & wmask);
  wire logic [31:0] merged_size = ({16'h0000, ring_size_q} & ~wmask) | (w_data_q & wmask);
  wire logic [`IRQ_WIDTH-1:0] clr_bits = wr_clr ? (w_data_q[`IRQ_WIDTH-1:0] &
    wmask[`IRQ_WIDTH-1:0]) : '0;
  wire logic [`IRQ_WIDTH-1:0] irq_set;
  assign irq_set[`IRQ_POSTED_BIT] = last_dw_done;
  assign irq_set[`IRQ_WRAP_BIT] = wrap;
  assign irq_set[`IRQ_OVERRUN_BIT] = overrun;

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
    end else if (clk_en_in) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? 2'b00 : 2'b10;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      run_q <= 1'b0;
      base_lo_q <= 32'h0000_0000;
      base_hi_q <= 32'h0000_0000;
      ring_size_q <= `RING_SIZE_RESET;
      irq_enable_q <= '0;
      irq_status_q <= '0;
      posted_cnt_q <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if (wr_ctrl && w_strb_q[0]) run_q <= w_data_q[`CTRL_RUN_BIT];
      if (wr_lo) base_lo_q <= {merged_lo[31:4], 4'h0};
      if (wr_hi) base_hi_q <= merged_hi;
      if (wr_size) ring_size_q <= (merged_size[15:0] < 16'h0002) ? 16'h0002 : merged_size[15:0];
      if (wr_en) irq_enable_q <= (irq_enable_q & ~wmask[`IRQ_WIDTH-1:0]) |
        (w_data_q[`IRQ_WIDTH-1:0] & wmask[`IRQ_WIDTH-1:0]);
      irq_status_q <= (irq_status_q & ~clr_bits) | irq_set;
      if (!run_q) posted_cnt_q <= 32'h0000_0000;
      else if (last_dw_done) posted_cnt_q <= posted_cnt_q + 32'h0000_0001;
    end
  end

  assign irq_out = |(irq_status_q & irq_enable_q);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // AXI4-Lite read path.
  assign s_axi_arready = !rvalid_q;
  wire logic [7:0] raddr = {s_axi_araddr[7:2], 2'b00};
  wire logic [31:0] ring_state = {15'h0000, phase, 16'(tail)};
  wire logic rd_hit = (raddr <= `REG_POSTED_CNT_OFS) && (raddr != `REG_IRQ_CLEAR_OFS);
  wire logic [31:0] rd_mux =
    (raddr == `REG_CTRL_OFS) ? {31'h0000_0000, run_q} :
    (raddr == `REG_RING_BASE_LO_OFS) ? base_lo_q :
    (raddr == `REG_RING_BASE_HI_OFS) ? base_hi_q :
    (raddr == `REG_RING_SIZE_OFS) ? {16'h0000, ring_size_q} :
    (raddr == `REG_RING_STATE_OFS) ? ring_state :
    (raddr == `REG_IRQ_STATUS_OFS) ? {29'h0000_0000, irq_status_q} :
    (raddr == `REG_IRQ_ENABLE_OFS) ? {29'h0000_0000, irq_enable_q} :
    (raddr == `REG_POSTED_CNT_OFS) ? posted_cnt_q : 32'h0000_0000;

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
    end else if (clk_en_in) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_hit ? rd_mux : 32'h0000_0000;
        rresp_q <= rd_hit ? 2'b00 : 2'b10;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule : completion_entry_builder

// *** tb/completion_entry_builder_chk.sv ***
/*
  Port assertions on the completion record builder.
  Assumes clk_en_in stays high while records are posted.
*/
`timescale 1ns/100ps
module completion_entry_builder_chk #(
  parameter int CODES = 8,
  parameter int IDX_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic cpl_valid_in,
  input wire logic cpl_ready_out,
  input wire logic [15:0] submission_queue_tag_in,
  input wire logic [15:0] queue_head_snapshot_in,
  input wire logic [15:0] command_tag_in,
  input wire logic [31:0] result_in,
  input wire logic result_used_in,
  input wire logic [2:0] status_category_in,
  input wire logic [CODES-1:0] code_flags_in,
  input wire logic dnr_in,
  input wire logic more_in,
  input wire logic mem_valid_out,
  input wire logic mem_ready_in,
  input wire logic [63:0] mem_addr_out,
  input wire logic [31:0] mem_data_out
);
  logic acc;
  logic [53:0] cap_q;
  assign acc = cpl_valid_in && cpl_ready_out;
  // Payload of the request in flight, kept for the later dwords.
  always_ff @(posedge sys_clk_in) begin
    if (acc) begin
      cap_q <= {submission_queue_tag_in, queue_head_snapshot_in, command_tag_in,
        status_category_in, dnr_in, more_in, code_flags_in == '0};
    end
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  sequence s_dw(logic [3:0] k);
    mem_valid_out && mem_addr_out[3:0] == k;
  endsequence
  property p_first;
    acc |-> ##2 s_dw(4'h0);
  endproperty
  property p_hold;
    mem_valid_out && !mem_ready_in |=>
      mem_valid_out && $stable(mem_addr_out) && $stable(mem_data_out);
  endproperty
  property p_next;
    (s_dw(4'h0) or s_dw(4'h4) or s_dw(4'h8)) ##0 mem_ready_in |=>
      mem_valid_out && mem_addr_out == $past(mem_addr_out) + 64'h4;
  endproperty
  property p_dw0;
    acc |-> ##2 mem_data_out == ($past(result_used_in, 2) ? $past(result_in, 2) : 32'h0);
  endproperty
  property p_dw1;
    s_dw(4'h4) |-> mem_data_out == 32'h0;
  endproperty
  property p_dw2;
    s_dw(4'h8) |-> mem_data_out == cap_q[53:22];
  endproperty
  property p_tag;
    s_dw(4'hC) |-> mem_data_out[15:0] == cap_q[21:6];
  endproperty
  property p_ok;
    s_dw(4'hC) ##0 cap_q[0] |-> mem_data_out[31:17] == 15'h0;
  endproperty
  property p_cat;
    s_dw(4'hC) ##0 !cap_q[0] |-> mem_data_out[27:25] == cap_q[5:3] &&
      mem_data_out[31:28] == {cap_q[2:1], 2'b00};
  endproperty
  property p_busy;
    acc |=> !cpl_ready_out [*4];
  endproperty
  a_first: assert property (p_first) else $error("first dword late");
  a_hold: assert property (p_hold) else $error("dword changed while stalled");
  a_next: assert property (p_next) else $error("dword order broken");
  a_dw0: assert property (p_dw0) else $error("dword zero wrong");
  a_dw1: assert property (p_dw1) else $error("dword one not zero");
  a_dw2: assert property (p_dw2) else $error("dword two wrong");
  a_tag: assert property (p_tag) else $error("command tag wrong");
  a_ok: assert property (p_ok) else $error("clean status not zero");
  a_cat: assert property (p_cat) else $error("status fields wrong");
  a_busy: assert property (p_busy) else $error("accept during posting");
endmodule : completion_entry_builder_chk

bind completion_entry_builder completion_entry_builder_chk #(.CODES(CODES), .IDX_W(IDX_W))
  u_completion_entry_builder_chk (.*);

// *** tb/host_ring_model.sv ***
/*
  Host memory ring behind the dword write port, stalling at random.
  Assumes one dword per valid/ready edge; reports each finished record.
*/
`timescale 1ns/100ps
module host_ring_model (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic clear_in,
  input wire logic mem_valid_in,
  input wire logic [63:0] mem_addr_in,
  input wire logic [31:0] mem_data_in,
  output logic mem_ready_out,
  output logic rec_stb_out,
  output logic [63:0] rec_addr_out,
  output logic [127:0] rec_data_out,
  output logic rec_flag_out
);
  logic [31:0] mem_q [logic [63:0]];
  logic [127:0] part_q;
  always @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mem_ready_out <= 1'b0;
      rec_stb_out <= 1'b0;
    end else begin
      rec_stb_out <= 1'b0;
      mem_ready_out <= ($urandom % 3) != 0;
      if (clear_in) begin
        mem_q.delete();
      end
      if (mem_valid_in && mem_ready_out) begin
        part_q[mem_addr_in[3:2]*32 +: 32] = mem_data_in;
        if (mem_addr_in[3:2] == 2'h3) begin
          rec_flag_out <= mem_q.exists(mem_addr_in) ? mem_q[mem_addr_in][16] : 1'b0;
          rec_stb_out <= 1'b1;
          rec_addr_out <= {mem_addr_in[63:4], 4'h0};
          rec_data_out <= part_q;
        end
        mem_q[mem_addr_in] = mem_data_in;
      end
    end
  end
endmodule : host_ring_model

// *** tb/tb.sv ***
/*
  Self-checking bench for the completion record builder.
  Assumes the host ring model answers the dword port; one 50 MHz clock.
*/
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [63:0] addr;
    logic [127:0] data;
  } exp_rec_t;
  logic sys_clk_in, reset_in, clk_en_in, host_clear, irq_out, rec_stb, rec_flag;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, code_flags_in;
  logic [31:0] s_axi_wdata, s_axi_rdata, result_in, mem_data_out;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cpl_valid_in, cpl_ready_out, result_used_in, dnr_in, more_in, mem_valid_out, mem_ready_in;
  logic [15:0] submission_queue_tag_in, queue_head_snapshot_in, command_tag_in;
  logic [2:0] status_category_in;
  logic [63:0] code_values_in, mem_addr_out, rec_addr, base_e;
  logic [127:0] rec_data;
  exp_rec_t rec_q[$];
  exp_rec_t got_e;
  logic [33:0] rd_q[$];
  int miscompares, samples_checked, tail_e, ring_n;
  logic phase_e;
  completion_entry_builder u_completion_entry_builder (.*);
  host_ring_model u_host_ring_model (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .clear_in(host_clear), .mem_valid_in(mem_valid_out), .mem_addr_in(mem_addr_out),
    .mem_data_in(mem_data_out), .mem_ready_out(mem_ready_in), .rec_stb_out(rec_stb),
    .rec_addr_out(rec_addr), .rec_data_out(rec_data), .rec_flag_out(rec_flag));
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: record got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_reg(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge sys_clk_in);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge sys_clk_in);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk_in); while (s_axi_bvalid !== 1'b1);
    chk_reg({s_axi_bresp, 32'h0}, {r, 32'h0});
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    rd_q.push_back(e);
    @(posedge sys_clk_in);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk_in); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk_in); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic post(input logic [7:0] fl);
    logic [15:0] sq, hd, cmd;
    logic [31:0] res;
    logic [63:0] cv;
    logic [7:0] low;
    logic [5:0] misc;
    exp_rec_t e;
    sq = 16'($urandom);
    hd = 16'($urandom);
    cmd = 16'($urandom);
    res = $urandom;
    cv = {$urandom, $urandom};
    misc = 6'($urandom);
    low = 8'hFF;
    for (int g = 0; g < 8; g++) begin
      if (fl[g] && cv[8*g +: 8] < low) begin
        low = cv[8*g +: 8];
      end
    end
    e.addr = base_e + 64'(tail_e) * 64'h10;
    e.data = {(fl == 8'h00) ? 15'h0 : {misc[5:4], 2'b00, misc[2:0], low}, phase_e, cmd,
      sq, hd, 32'h0, misc[3] ? res : 32'h0};
    rec_q.push_back(e);
    tail_e++;
    if (tail_e == ring_n) begin
      tail_e = 0;
      phase_e = ~phase_e;
    end
    @(posedge sys_clk_in);
    cpl_valid_in <= 1'b1;
    {submission_queue_tag_in, queue_head_snapshot_in, command_tag_in} <= {sq, hd, cmd};
    {result_in, result_used_in, code_flags_in, code_values_in} <= {res, misc[3], fl, cv};
    {dnr_in, more_in, status_category_in} <= {misc[5:4], misc[2:0]};
    do @(posedge sys_clk_in); while (cpl_ready_out !== 1'b1);
    cpl_valid_in <= 1'b0;
  endtask : post
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  always @(posedge sys_clk_in) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      chk_reg({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
    end
    if (rec_stb === 1'b1) begin
      got_e = rec_q.pop_front();
      chk_word(rec_addr, got_e.addr);
      chk_word(rec_data[63:0], got_e.data[63:0]);
      chk_word(rec_data[95:64], got_e.data[95:64]);
      chk_word(rec_data[127:113], got_e.data[127:113]);
      chk_word(rec_data[112:96], got_e.data[112:96]);
      chk_word(rec_data[112], {~rec_flag});
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    void'($urandom(17618));
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cpl_valid_in} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, result_in, code_values_in, code_flags_in} = '0;
    {submission_queue_tag_in, queue_head_snapshot_in, command_tag_in, status_category_in} = '0;
    {result_used_in, dnr_in, more_in, host_clear} = '0;
    s_axi_wstrb = 4'hF;
    clk_en_in = 1'b1;
    reset_in = 1'b1;
    {miscompares, samples_checked, tail_e} = '0;
    phase_e = 1'b1;
    base_e = 64'h0000_0001_0000_2000;
    ring_n = 3;
    repeat (3) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    axi_rd(8'h00, 34'h0);
    axi_rd(8'h0C, 34'h0_0000_0010);
    axi_rd(8'h10, 34'h0_0001_0000);
    axi_rd(8'h20, 34'h0);
    axi_rd(8'h24, 34'h2_0000_0000);
    axi_wr(8'h24, 32'hFFFF_FFFF, 2'b10);
    $display("test reset_values done");
    @(posedge sys_clk_in);
    cpl_valid_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk_word(cpl_ready_out, 64'h0);
    cpl_valid_in <= 1'b0;
    axi_rd(8'h14, 34'h0_0000_0004);
    axi_wr(8'h18, 32'h0000_0004, 2'b00);
    chk_word(irq_out, 64'h1);
    axi_wr(8'h18, 32'h0000_0000, 2'b00);
    chk_word(irq_out, 64'h0);
    axi_wr(8'h1C, 32'h0000_0004, 2'b00);
    axi_rd(8'h14, 34'h0);
    $display("test stopped_requests done");
    axi_wr(8'h04, 32'h0000_2000, 2'b00);
    axi_wr(8'h08, 32'h0000_0001, 2'b00);
    axi_wr(8'h0C, 32'h0000_0003, 2'b00);
    axi_wr(8'h18, 32'h0000_0003, 2'b00);
    axi_wr(8'h00, 32'h0000_0001, 2'b00);
    for (int i = 0; i < 7; i++) begin
      post((i == 2) ? 8'h00 : 8'($urandom));
    end
    while (rec_q.size() != 0) @(posedge sys_clk_in);
    axi_rd(8'h10, 34'h0_0001_0001);
    axi_rd(8'h20, 34'h0_0000_0007);
    axi_rd(8'h14, 34'h0_0000_0003);
    chk_word(irq_out, 64'h1);
    $display("test ring_passes done");
    axi_wr(8'h00, 32'h0000_0000, 2'b00);
    axi_rd(8'h10, 34'h0_0001_0000);
    axi_rd(8'h20, 34'h0);
    @(posedge sys_clk_in);
    host_clear <= 1'b1;
    @(posedge sys_clk_in);
    host_clear <= 1'b0;
    tail_e = 0;
    phase_e = 1'b1;
    axi_wr(8'h00, 32'h0000_0001, 2'b00);
    post(8'($urandom));
    post(8'($urandom));
    while (rec_q.size() != 0) @(posedge sys_clk_in);
    $display("test restart done");
    summarize();
  end
endmodule : tb
